// ===== rtl/counter_pulse_gen.v
/*
 * Counter output side (single, retriggerable, train, equivalent-time pulses)
 * plus the frequency generator, reached over an Avalon-MM slave.
 * Assumes gate, source and hardware arm inputs synchronous to clk.
 */
// Functional notes
// RQ1: Triggered mode gives exactly one pulse
// RQ2: Delay and width count source edges
// RQ3: Non-retriggerable mode ignores gate after trigger
// RQ4: Retriggerable gives pulse per accepted trigger
// RQ5: Gate ignored while retriggered pulse runs
// RQ6: Train waits programmed delay after arming
// RQ7: Separate high/low counts; source edge selectable
// RQ8: Train starts on arm or trigger
// RQ9: Gate as pause trigger halts train
// RQ10: Train frequency is source over M+N
// RQ11: Frequency generator has its own divider
// RQ12: Frequency output is timebase over 1..16; a divider of one gives timebase over 2
// RQ13: Timebase is 20 MHz/2 or 100 kHz
// RQ14: Divider one or even gives half duty
// RQ15: Odd divider low (D+1)/2, high (D-1)/2
// RQ16: Terminal drivers disabled at power-up
// RQ17: Frequency output routable to several terminals
// RQ18: Equivalent-time delay grows by increment each trigger
// RQ19: Increment programmable from 0 to 255
// RQ20: Equivalent-time repeats until disarmed
// RQ21: Gate ignored while equivalent-time pulse runs
// RQ22: Pulses drive the internal output signal
// RQ23: Terminal count asserts at count zero
// RQ24: Output pulses or toggles; polarity selectable
// RQ25: Generation starts only after arming
// RQ26: Load count, decrement on source edges
// RQ27: Settings latched at arming
`include "pulse_gen_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module counter_pulse_gen #(
    parameter WIDTH = 32
) (
    input wire clk,
    input wire rst_b,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire source_in,
    input wire gate_in,
    input wire hw_arm_in,
    output reg internal_output,
    output reg terminal_count,
    output wire divided_frequency_output,
    output wire [7:0] terminal_out,
    output wire [7:0] terminal_oe
);

    //----------------------------------------------------------------
    // Register file
    //----------------------------------------------------------------

    reg [31:0] ctrl_reg;
    reg [WIDTH-1:0] delay_reg;
    reg [WIDTH-1:0] high_reg;
    reg [WIDTH-1:0] low_reg;
    reg [7:0] incr_reg;
    reg [5:0] freq_reg;
    reg [15:0] route_reg;
    reg ack_reg;
    reg armed_reg;
    reg [2:0] state_reg;
    reg [WIDTH-1:0] count_reg;
    wire access;

    // Each access waits one cycle, then completes in the next.
    assign access = avs_read | avs_write;
    assign avs_waitrequest = access & ~ack_reg;

    // Acknowledge toggles so back-to-back requests each wait once.
    always @(posedge clk) begin
        if (!rst_b)
            ack_reg <= 1'b0;
        else
            ack_reg <= access & ~ack_reg;
    end

    // Register writes; the arm bit is cleared by software writing zero.
    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg <= `CTRL_RESET;
            delay_reg <= `COUNT_RESET;
            high_reg <= `COUNT_RESET;
            low_reg <= `COUNT_RESET;
            incr_reg <= 8'h00;
            freq_reg <= 6'h00;
            route_reg <= 16'h0000; // [RQ16]
        end else if (avs_write && ack_reg) begin
            case (avs_address)
                `OFS_CTRL: ctrl_reg <= {20'h00000, avs_writedata[11:0]};
                `OFS_DELAY: delay_reg <= avs_writedata[WIDTH-1:0];
                `OFS_HIGH: high_reg <= avs_writedata[WIDTH-1:0];
                `OFS_LOW: low_reg <= avs_writedata[WIDTH-1:0];
                `OFS_INCR: incr_reg <= avs_writedata[7:0]; // [RQ19]
                `OFS_FREQ: freq_reg <= avs_writedata[5:0];
                `OFS_ROUTE: route_reg <= avs_writedata[15:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Read data is registered at the acknowledging edge; unmapped reads zero.
    always @(posedge clk) begin
        if (!rst_b) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_reg) begin
            case (avs_address)
                `OFS_CTRL: avs_readdata <= ctrl_reg;
                `OFS_DELAY: avs_readdata <= delay_reg;
                `OFS_HIGH: avs_readdata <= high_reg;
                `OFS_LOW: avs_readdata <= low_reg;
                `OFS_INCR: avs_readdata <= {24'h000000, incr_reg};
                `OFS_FREQ: avs_readdata <= {26'h0000000, freq_reg};
                `OFS_STATUS: avs_readdata <= {count_reg[23:0], 2'b00, state_reg, terminal_count,
                    internal_output, armed_reg};
                `OFS_ROUTE: avs_readdata <= {16'h0000, route_reg};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    //----------------------------------------------------------------
    // Edge detection
    //----------------------------------------------------------------

    reg src_d_reg;
    reg gate_d_reg;
    reg hw_arm_d_reg;
    wire src_edge;
    wire gate_edge;
    wire paused;

    // Previous-sample flops for edge detection on synchronous inputs.
    always @(posedge clk) begin
        if (!rst_b) begin
            src_d_reg <= 1'b0;
            gate_d_reg <= 1'b0;
            hw_arm_d_reg <= 1'b0;
        end else begin
            src_d_reg <= source_in;
            gate_d_reg <= gate_in;
            hw_arm_d_reg <= hw_arm_in;
        end
    end

    assign src_edge = ctrl_reg[`CTRL_SRC_FALL] ? (src_d_reg & ~source_in)
                                               : (~src_d_reg & source_in); // [RQ7]
    assign gate_edge = ctrl_reg[`CTRL_GATE_FALL] ? (gate_d_reg & ~gate_in) : (~gate_d_reg & gate_in);
    assign paused = ctrl_reg[`CTRL_PAUSE_EN] & ~ctrl_reg[`CTRL_USE_TRIG] &
                    (gate_in == ctrl_reg[`CTRL_PAUSE_LVL]); // [RQ9]

    //----------------------------------------------------------------
    // Generation state machine
    //----------------------------------------------------------------

    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT_TRIG = 3'h1;
    localparam ST_DELAY = 3'h2;
    localparam ST_HIGH = 3'h3;
    localparam ST_LOW = 3'h4;
    localparam ST_DONE = 3'h5;

    reg [2:0] mode_reg;
    reg [WIDTH-1:0] lat_delay_reg;
    reg [WIDTH-1:0] lat_high_reg;
    reg [WIDTH-1:0] lat_low_reg;
    reg [7:0] lat_incr_reg;
    reg active_reg;
    wire arm_req;
    wire count_end;

    // Reloads a count; a programmed zero behaves as one edge.
    function [WIDTH-1:0] load_count;
        input [WIDTH-1:0] value;
        begin
            load_count = (value == {WIDTH{1'b0}}) ? {{(WIDTH-1){1'b0}}, 1'b1} : value;
        end
    endfunction

    // Arm by software; when hardware arm is enabled, also wait for a rising edge on the hardware arm input.
    assign arm_req = ctrl_reg[`CTRL_ARM] &
                     (~ctrl_reg[`CTRL_HW_ARM_EN] | (hw_arm_in & ~hw_arm_d_reg)); // [RQ25]
    assign count_end = src_edge && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});

    // Counter loads a count and decrements on active source edges.
    always @(posedge clk) begin
        if (!rst_b || !ctrl_reg[`CTRL_ARM]) begin
            state_reg <= ST_IDLE;
            armed_reg <= 1'b0;
            active_reg <= 1'b0;
            count_reg <= {WIDTH{1'b0}};
            mode_reg <= `MODE_SINGLE;
            lat_delay_reg <= {WIDTH{1'b0}};
            lat_high_reg <= {WIDTH{1'b0}};
            lat_low_reg <= {WIDTH{1'b0}};
            lat_incr_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (arm_req) begin
                        armed_reg <= 1'b1;
                        mode_reg <= ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
                        lat_delay_reg <= delay_reg; // [RQ27]
                        lat_high_reg <= high_reg;
                        lat_low_reg <= low_reg;
                        lat_incr_reg <= incr_reg;
                        count_reg <= load_count(delay_reg);
                        if (ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_SINGLE ||
                            (ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_TRAIN &&
                             !ctrl_reg[`CTRL_USE_TRIG]))
                            state_reg <= ST_DELAY; // [RQ8] [RQ6]
                        else
                            state_reg <= ST_WAIT_TRIG;
                    end
                end
                ST_WAIT_TRIG: begin
                    // Only the waiting state looks at the gate edge.
                    if (gate_edge) begin
                        count_reg <= load_count(lat_delay_reg); // [RQ1] [RQ4] [RQ18]
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (!paused && src_edge) begin
                        if (count_end) begin
                            count_reg <= load_count(lat_high_reg); // [RQ2] [RQ26]
                            state_reg <= ST_HIGH;
                        end else begin
                            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                        end
                    end
                end
                ST_HIGH: begin
                    if (!paused && src_edge) begin
                        if (count_end) begin
                            if (mode_reg == `MODE_TRAIN) begin
                                count_reg <= load_count(lat_low_reg); // [RQ7] [RQ10]
                                state_reg <= ST_LOW;
                            end else if (mode_reg == `MODE_RETRIG) begin
                                state_reg <= ST_WAIT_TRIG; // [RQ5]
                            end else if (mode_reg == `MODE_ETS) begin
                                lat_delay_reg <= lat_delay_reg + {{(WIDTH-8){1'b0}}, lat_incr_reg}; // [RQ18]
                                state_reg <= ST_WAIT_TRIG; // [RQ20] [RQ21]
                            end else begin
                                state_reg <= ST_DONE; // [RQ3]
                            end
                        end else begin
                            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                        end
                    end
                end
                ST_LOW: begin
                    if (!paused && src_edge) begin
                        if (count_end) begin
                            count_reg <= load_count(lat_high_reg); // [RQ10]
                            state_reg <= ST_HIGH;
                        end else begin
                            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                        end
                    end
                end
                ST_DONE: begin
                    count_reg <= {WIDTH{1'b0}};
                end
                default: state_reg <= ST_IDLE;
            endcase
            active_reg <= (state_reg == ST_DELAY) || (state_reg == ST_HIGH) || (state_reg == ST_LOW);
        end
    end

    //----------------------------------------------------------------
    // Terminal count and internal output
    //----------------------------------------------------------------

    wire tc_event;
    wire level_next;

    // Terminal count fires when a phase count reaches zero.
    assign tc_event = !paused && count_end &&
                      (state_reg == ST_DELAY || state_reg == ST_HIGH || state_reg == ST_LOW); // [RQ23]
    assign level_next = (state_reg == ST_DELAY) || (state_reg == ST_LOW);

    // Output either tracks the pulse level or toggles on terminal count.
    always @(posedge clk) begin
        if (!rst_b) begin
            terminal_count <= 1'b0;
            internal_output <= 1'b0;
        end else begin
            terminal_count <= tc_event;
            if (!ctrl_reg[`CTRL_ARM])
                internal_output <= ctrl_reg[`CTRL_INVERT];
            else if (!ctrl_reg[`CTRL_TOGGLE])
                internal_output <= ctrl_reg[`CTRL_INVERT] ^
                    (tc_event ? level_next : (state_reg == ST_HIGH && !count_end) |
                     (state_reg == ST_HIGH && paused)); // [RQ22] [RQ24]
            else if (tc_event && state_reg != ST_DELAY)
                internal_output <= ~internal_output; // [RQ24]
            else if (tc_event)
                internal_output <= ~ctrl_reg[`CTRL_INVERT];
        end
    end

    //----------------------------------------------------------------
    // Frequency generator and terminal routing
    //----------------------------------------------------------------

    freq_divider u_freq (
        .clk(clk),
        .rst_b(rst_b),
        .enable(freq_reg[`FREQ_EN]),
        .slow_sel(freq_reg[`FREQ_SLOW]),
        .divider(freq_reg[`FREQ_DIV_HI:`FREQ_DIV_LO]),
        .divided_frequency_output(divided_frequency_output)
    );

    // Low byte enables each terminal; high byte picks frequency or counter output.
    assign terminal_oe = route_reg[7:0]; // [RQ16]
    assign terminal_out = (route_reg[15:8] & {8{divided_frequency_output}}) |
                          (~route_reg[15:8] & {8{internal_output}}); // [RQ17]

endmodule

`default_nettype wire

// ===== rtl/freq_divider.v
/*
 * Frequency generator: divides a selected timebase by 2 to 16; a divider of one divides by 2.
 * Assumes a single clock; timebase enables are one-cycle pulses.
 */
`include "pulse_gen_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module freq_divider #(
    parameter SLOW_CYCLES = `SLOW_TB_CYCLES
) (
    input wire clk,
    input wire rst_b,
    input wire enable,
    input wire slow_sel,
    input wire [3:0] divider,
    output reg divided_frequency_output
);

    //----------------------------------------------------------------
    // Timebase enables
    //----------------------------------------------------------------

    reg half_reg;
    reg [15:0] slow_cnt_reg;
    wire tick;

    // Half-rate enable from the 20 MHz clock and a 100 kHz enable, own divider.
    always @(posedge clk) begin
        if (!rst_b) begin
            half_reg <= 1'b0;
            slow_cnt_reg <= 16'h0000;
        end else begin
            half_reg <= ~half_reg;
            if (slow_cnt_reg == SLOW_CYCLES - 1)
                slow_cnt_reg <= 16'h0000;
            else
                slow_cnt_reg <= slow_cnt_reg + 16'h0001;
        end
    end

    assign tick = slow_sel ? (slow_cnt_reg == 16'h0000) : half_reg; // [RQ13] [RQ11]

    //----------------------------------------------------------------
    // Divider
    //----------------------------------------------------------------

    reg [4:0] phase_reg;
    wire [4:0] div_n;
    wire [4:0] low_len;

    assign div_n = (divider == 4'h0) ? 5'h10 : {1'b0, divider}; // Zero code means sixteen.
    assign low_len = (div_n + 5'h01) >> 1;

    // Phase runs 0..D-1; low for the first (D+1)/2, high for the rest.
    always @(posedge clk) begin
        if (!rst_b || !enable) begin
            phase_reg <= 5'h00;
            divided_frequency_output <= 1'b0;
        end else if (tick) begin
            if (div_n == 5'h01) begin
                divided_frequency_output <= ~divided_frequency_output; // [RQ14]
            end else begin
                if (phase_reg >= div_n - 5'h01)
                    phase_reg <= 5'h00;
                else
                    phase_reg <= phase_reg + 5'h01;
                divided_frequency_output <= (phase_reg + 5'h01 >= low_len) &&
                    (phase_reg + 5'h01 < div_n); // [RQ12] [RQ14] [RQ15]
            end
        end
    end

endmodule

`default_nettype wire

// ===== rtl/pulse_gen_consts.vh
/*
 * Holds register offsets, field positions, reset values, mode codes and
 * timing figures shared by the pulse and frequency generator.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef PULSE_GEN_CONSTS_VH
`define PULSE_GEN_CONSTS_VH

// Register word offsets on the Avalon-MM slave (word index, not scaled by four).
`define OFS_CTRL 4'h0
`define OFS_DELAY 4'h1
`define OFS_HIGH 4'h2
`define OFS_LOW 4'h3
`define OFS_INCR 4'h4
`define OFS_FREQ 4'h5
`define OFS_STATUS 4'h6
`define OFS_ROUTE 4'h7

// Control register field positions.
`define CTRL_ARM 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 3
`define CTRL_SRC_FALL 4
`define CTRL_GATE_FALL 5
`define CTRL_USE_TRIG 6
`define CTRL_PAUSE_EN 7
`define CTRL_PAUSE_LVL 8
`define CTRL_TOGGLE 9
`define CTRL_INVERT 10
`define CTRL_HW_ARM_EN 11

// Frequency register field positions.
`define FREQ_DIV_LO 0
`define FREQ_DIV_HI 3
`define FREQ_SLOW 4
`define FREQ_EN 5

// Generation modes.
`define MODE_SINGLE 3'h0
`define MODE_TRIG_SINGLE 3'h1
`define MODE_RETRIG 3'h2
`define MODE_TRAIN 3'h3
`define MODE_ETS 3'h4

// Reset values.
`define CTRL_RESET 32'h00000000
`define COUNT_RESET 32'h00000001
`define FREQ_RESET 32'h00000000
`define ROUTE_RESET 32'h00000000

// Timing: the slow timebase is 100 kHz, derived from the 20 MHz clock.
`define CLK_HZ 20000000
`define SLOW_TB_HZ 100000
`define SLOW_TB_CYCLES (`CLK_HZ / `SLOW_TB_HZ)

`endif

// ===== verif/counter_pulse_gen_bench.sv
/*
 * Self-checking bench: bus tasks, pulse scenarios and divider sweep.
 * Assumes ext_signals drives source, gate and hardware arm.
 */
`timescale 1ns/1ps
`default_nettype none

module counter_pulse_gen_bench;
    logic clk, rst_b, avs_read, avs_write, source_in, gate_in, hw_arm_in;
    logic internal_output, terminal_count, divided_frequency_output, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] terminal_out, terminal_oe;
    int n_fail, n_compared, cycles, nr, hi, lo, ntc, ng, eh, el;
    int rt[4], gt[4];

    counter_pulse_gen counter_pulse_gen_i (.*);
    ext_signals ext_signals_i (.*);

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cuts a hang short well past the expected run length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Avalon-MM master and output measurement
    // ----------------------------------------
    task automatic bus(input logic wr_n, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr_n;
        avs_read <= !wr_n;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask

    // Counts rises, first high and low lengths, gate and output rise times.
    task automatic measure(input logic sel, input int n);
        logic pv, pg, cv;
        int st;
        {nr, hi, lo, ntc, ng, st} = '0;
        pv = sel ? divided_frequency_output : internal_output;
        pg = gate_in;
        repeat (n) begin
            @(negedge clk);
            cv = sel ? divided_frequency_output : internal_output;
            if (terminal_count === 1'b1) ntc++;
            if (gate_in && !pg && ng < 4) gt[ng++] = cycles;
            if (cv && !pv) begin
                if (nr < 4) rt[nr] = cycles;
                nr++;
                if (st == 0) st = 1;
            end
            if (st == 1 && !cv) st = 2;
            if (st == 2 && cv) st = 3;
            if (st == 1) hi++;
            if (st == 2) lo++;
            pv = cv;
            pg = gate_in;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst_b, avs_read, avs_write, cycles, n_fail, n_compared} = '0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rdc("ctrl", 4'h0, 32'h0);
        rdc("delay", 4'h1, 32'h1);
        rdc("freq", 4'h5, 32'h0);
        rdc("route", 4'h7, 32'h0);
        rdc("unmapped", 4'h8, 32'h0);
        check("oe", terminal_oe, 8'h00);
        wr(4'h1, 32'h2);
        wr(4'h2, 32'h3);
        wr(4'h3, 32'h3);
        for (int m = 1; m < 3; m++) begin
            wr(4'h0, 32'h0);
            wr(4'h0, 32'h1 | (m << 1));
            fork
                measure(1'b0, 200);
                begin
                    ext_signals_i.gate_pulse();
                    repeat (4) @(posedge clk);
                    ext_signals_i.gate_pulse();
                    repeat (80) @(posedge clk);
                    ext_signals_i.gate_pulse();
                end
            join
            check("pulses", nr, m);
            check("width", hi, 12);
            check("tc", ntc != 0, 1);
        end
        wr(4'h2, 32'h2);
        for (int f = 0; f < 2; f++) begin
            wr(4'h0, 32'h0);
            wr(4'h0, 32'h7 | (f << 4));
            measure(1'b0, 100);
            check("train_hi", hi, 8);
            check("train_lo", lo, 12);
        end
        wr(4'h0, 32'h0);
        wr(4'h0, 32'h47);
        measure(1'b0, 60);
        check("trig_wait", nr, 0);
        fork
            measure(1'b0, 100);
            ext_signals_i.gate_pulse();
        join
        check("trig_hi", hi, 8);
        wr(4'h0, 32'h0);
        ext_signals_i.gate_level(1'b1);
        wr(4'h0, 32'h187);
        measure(1'b0, 80);
        check("paused", nr, 0);
        ext_signals_i.gate_level(1'b0);
        measure(1'b0, 100);
        check("resumed", hi, 8);
        wr(4'h0, 32'h0);
        wr(4'h0, 32'h807);
        measure(1'b0, 60);
        check("hw_wait", nr, 0);
        fork
            measure(1'b0, 100);
            ext_signals_i.hw_arm_pulse();
        join
        check("hw_hi", hi, 8);
        wr(4'h0, 32'h0);
        wr(4'h2, 32'h1);
        wr(4'h4, 32'h3);
        wr(4'h0, 32'h9);
        fork
            measure(1'b0, 300);
            repeat (3) begin
                ext_signals_i.gate_pulse();
                repeat (80) @(posedge clk);
            end
        join
        check("ets_count", nr, 3);
        check("ets_step1", (rt[1] - gt[1]) - (rt[0] - gt[0]), 12);
        check("ets_step2", (rt[2] - gt[2]) - (rt[1] - gt[1]), 12);
        for (int d = 1; d <= 16; d++) begin
            wr(4'h5, 32'h20 | (d & 15));
            repeat (40) @(posedge clk);
            measure(1'b1, 80);
            eh = (d == 1) ? 2 : ((d % 2) ? d - 1 : d);
            el = (d == 1) ? 2 : ((d % 2) ? d + 1 : d);
            check("freq_hi", hi, eh);
            check("freq_lo", lo, el);
        end
        wr(4'h5, 32'h32);
        repeat (400) @(posedge clk);
        measure(1'b1, 900);
        check("slow_hi", hi, 200);
        wr(4'h7, 32'h0fff);
        @(negedge clk);
        check("oe_set", terminal_oe, 8'hff);
        check("t0_freq", terminal_out[0], divided_frequency_output);
        check("t7_out", terminal_out[7], internal_output);
        wr(4'h0, 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire

// ===== verif/ext_signals.sv
/*
 * Far-side model: source timebase, gate and hardware arm.
 * Assumes the bench calls its tasks from procedural code.
 */
`timescale 1ns/1ps
`default_nettype none

module ext_signals (
    input wire logic clk,
    input wire logic rst_b,
    output logic source_in,
    output logic gate_in,
    output logic hw_arm_in
);
    logic [1:0] ph;

    // Free-running source with a period of four clocks.
    always @(posedge clk) begin
        if (!rst_b) ph <= 2'h0;
        else ph <= ph + 2'h1;
    end
    assign source_in = ph[1];

    initial begin
        gate_in = 1'b0;
        hw_arm_in = 1'b0;
    end

    // Gate pulses start at a fixed source phase so delays compare exactly.
    task automatic gate_pulse();
        @(posedge clk iff ph == 2'h3);
        gate_in <= 1'b1;
        repeat (4) @(posedge clk);
        gate_in <= 1'b0;
    endtask

    task automatic gate_level(input logic v);
        @(posedge clk);
        gate_in <= v;
    endtask

    // Hardware arm as an external rising edge.
    task automatic hw_arm_pulse();
        @(posedge clk);
        hw_arm_in <= 1'b1;
        repeat (2) @(posedge clk);
        hw_arm_in <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== verif/pulse_gen_properties.sv
/*
 * Concurrent checks on the ports of counter_pulse_gen.
 * Assumes one clock, synchronous active-low reset and the bind below.
 */
`timescale 1ns/1ps
`default_nettype none

module pulse_gen_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic source_in,
    input wire logic gate_in,
    input wire logic hw_arm_in,
    input wire logic internal_output,
    input wire logic terminal_count,
    input wire logic divided_frequency_output,
    input wire logic [7:0] terminal_out,
    input wire logic [7:0] terminal_oe
);
    logic [15:0] route_sh;
    logic cfg_seen;
    logic freq_seen;
    logic taken;

    // ----------------------------------------
    // Shadows of what software has written
    // ----------------------------------------
    assign taken = (avs_read | avs_write) & ~avs_waitrequest;

    // Tracks routing and whether counter or divider were ever configured.
    always @(posedge clk) begin
        if (!rst_b) begin
            route_sh <= 16'h0000;
            cfg_seen <= 1'b0;
            freq_seen <= 1'b0;
        end else if (avs_write && taken) begin
            if (avs_address == 4'h7) route_sh <= avs_writedata[15:0];
            if (avs_address == 4'h0) cfg_seen <= 1'b1;
            if (avs_address == 4'h5) freq_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    oe_after_reset_a: assert property ($rose(rst_b) |-> terminal_oe == 8'h00 && !internal_output)
        else $error("terminals driven or output high after reset");
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
    idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    tc_single_a: assert property (terminal_count |=> !terminal_count)
        else $error("terminal count wider than one cycle");
    quiet_disarmed_a: assert property (!cfg_seen |-> !internal_output && !terminal_count)
        else $error("counter active before any arming");
    freq_quiet_a: assert property (!freq_seen |-> !divided_frequency_output)
        else $error("divider output active before setup");
    route_oe_a: assert property (avs_write && taken && avs_address == 4'h7 |=> terminal_oe == route_sh[7:0])
        else $error("terminal enables differ from routing write");
    term_select_a: assert property (terminal_out == ((route_sh[15:8] & {8{divided_frequency_output}})
        | (~route_sh[15:8] & {8{internal_output}})))
        else $error("terminal data does not follow routing");
    unmapped_read_a: assert property (avs_read && taken && avs_address > 4'h7 |-> avs_readdata == 32'h0)
        else $error("unmapped read returned nonzero");

    tc_seen_c: cover property (terminal_count);
    status_read_c: cover property (avs_read && taken && avs_address == 4'h6);
    freq_rise_c: cover property ($rose(divided_frequency_output));
endmodule

bind counter_pulse_gen pulse_gen_properties pulse_gen_properties_i (.*);

`default_nettype wire
